//--- rtl/mac_timer.sv
/*
  MAC timer configuration, status and count access, seen from the SFR bus.
  Assumes the controller issues at most one strobe per cycle on the bus.
*/
// Decided for this implementation: the AHB-Lite interface to the registers.
// Operation
// - compare flag set on selected byte match
// - period flag set on period event
// - overflow compare flag set on event
// - flags set by hardware, write 0 clears
// - compare source selects high or low byte
// - software writes zero to reserved bit
// - sync off: start or stop immediately
// - sync on: act on next slow tick
// - sync enable is one after reset
// - run bit write starts or stops timer
// - run bit reads actual timer state
// - sync run status changes at actual event
// - high byte read returns shadow from low read
// - high write while idle loads upper byte
// - period event when count reaches period
// - delta decrements, sticks at zero
// - low write while running waits for high
// - software avoids zero period in low power
`timescale 1ns/1ps
module mac_timer (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // Register bus
  sfr_bus_if.timer BUS,
  // Overflow counter compare event from the overflow logic
  input wire logic OVF_COMPARE_EVENT,
  // Status
  output logic TIMER_RUNNING,
  output logic PERIOD_EVENT
);
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] period;
    logic [15:0] delta;
    logic [7:0] low_written;
    logic [7:0] shadow_high;
    logic [7:0] compare;
    logic cmp_flag;
    logic per_flag;
    logic ofc_flag;
    logic cmp_src;
    logic reserved;
    logic sync_en;
    logic running;
    logic run_req;
    logic pending;
    logic period_event;
    logic [7:0] rdata;
    logic rvalid;
  } state_t;

  state_t cur;
  state_t next_cur;
  logic tick;
  logic [7:0] cfg_read;
  logic cmp_hit;
  logic per_hit;

  // The divider runs free, so a synced start or stop waits up to one full tick period.
  sync_tick_gen #(.CYCLES(mac_timer_pkg::SYNC_TICK_CYCLES)) u_tick (
    .clk(SYS_CLK),
    .reset_n(RESET_N),
    .tick(tick)
  );

  always_comb begin
    // Placing fields by their package positions keeps the map in one place.
    cfg_read = 8'h00;
    cfg_read[mac_timer_pkg::CFG_COMPARE_FLAG] = cur.cmp_flag;
    cfg_read[mac_timer_pkg::CFG_PERIOD_FLAG] = cur.per_flag;
    cfg_read[mac_timer_pkg::CFG_OVF_COMPARE_FLAG] = cur.ofc_flag;
    cfg_read[mac_timer_pkg::CFG_UNUSED] = 1'b0;
    cfg_read[mac_timer_pkg::CFG_COMPARE_SOURCE] = cur.cmp_src;
    cfg_read[mac_timer_pkg::CFG_RESERVED] = cur.reserved;
    cfg_read[mac_timer_pkg::CFG_SYNC_ENABLE] = cur.sync_en;
    cfg_read[mac_timer_pkg::CFG_RUN] = cur.running;
    // The compare keeps matching while the count is frozen, so a flag
    // cleared during a delta halt may come straight back.
    cmp_hit = cur.running && (cur.compare ==
      (cur.cmp_src ? cur.count[7:0] : cur.count[15:8]));
    // The period check waits out a delta too, so a halt stretches its period.
    per_hit = cur.running && (cur.delta == 16'h0000) &&
      (cur.count >= cur.period);
  end

  always_comb begin
    next_cur = cur;
    next_cur.rvalid = 1'b0;
    next_cur.period_event = 1'b0;
    // Counting, halted while a delta is outstanding.
    // A new delta replaces one still counting; halts do not add up.
    if (cur.running) begin
      if (cur.delta != 16'h0000) begin
        next_cur.delta = cur.delta - 16'h0001;
      end else if (per_hit) begin
        next_cur.count = 16'h0000;
        next_cur.period_event = 1'b1;
      end else begin
        next_cur.count = cur.count + 16'h0001;
      end
    end
    // Start and stop.
    // A synced start resumes the count where it stopped; it does not
    // recompute the count from the slow clock.
    if (cur.pending && tick) begin
      next_cur.running = cur.run_req;
      next_cur.pending = 1'b0;
    end
    // Bus reads.
    if (BUS.rd) begin
      next_cur.rvalid = 1'b1;
      case (BUS.addr)
        mac_timer_pkg::TIMER_CONFIGURATION: next_cur.rdata = cfg_read;
        mac_timer_pkg::TIMER_COUNT_LOW_BYTE: begin
          next_cur.rdata = cur.count[7:0];
          // The shadow keeps a two-byte read coherent while the count moves on.
          next_cur.shadow_high = cur.count[15:8];
        end
        mac_timer_pkg::TIMER_COUNT_HIGH_BYTE: next_cur.rdata = cur.shadow_high;
        mac_timer_pkg::TIMER_COMPARE_VALUE: next_cur.rdata = cur.compare;
        mac_timer_pkg::TIMER_PERIOD_LOW: next_cur.rdata = cur.period[7:0];
        mac_timer_pkg::TIMER_PERIOD_HIGH: next_cur.rdata = cur.period[15:8];
        default: next_cur.rdata = 8'h00;
      endcase
    end
    // Bus writes.
    if (BUS.wr) begin
      case (BUS.addr)
        mac_timer_pkg::TIMER_CONFIGURATION: begin
          // Write 0 clears a flag, write 1 leaves it.
          next_cur.cmp_flag = cur.cmp_flag & BUS.wdata[mac_timer_pkg::CFG_COMPARE_FLAG];
          next_cur.per_flag = cur.per_flag & BUS.wdata[mac_timer_pkg::CFG_PERIOD_FLAG];
          next_cur.ofc_flag = cur.ofc_flag & BUS.wdata[mac_timer_pkg::CFG_OVF_COMPARE_FLAG];
          next_cur.cmp_src = BUS.wdata[mac_timer_pkg::CFG_COMPARE_SOURCE];
          next_cur.reserved = BUS.wdata[mac_timer_pkg::CFG_RESERVED];
          next_cur.sync_en = BUS.wdata[mac_timer_pkg::CFG_SYNC_ENABLE];
          if (BUS.wdata[mac_timer_pkg::CFG_SYNC_ENABLE]) begin
            next_cur.run_req = BUS.wdata[mac_timer_pkg::CFG_RUN];
            next_cur.pending = 1'b1;
          end else begin
            next_cur.running = BUS.wdata[mac_timer_pkg::CFG_RUN];
            next_cur.pending = 1'b0;
          end
        end
        mac_timer_pkg::TIMER_COUNT_LOW_BYTE: begin
          // While running, the low byte only waits for the high byte to form a delta.
          next_cur.low_written = BUS.wdata;
          if (!cur.running) begin
            next_cur.count[7:0] = BUS.wdata;
          end
        end
        mac_timer_pkg::TIMER_COUNT_HIGH_BYTE: begin
          if (cur.running) begin
            next_cur.delta = {BUS.wdata, cur.low_written};
          end else begin
            next_cur.count[15:8] = BUS.wdata;
          end
        end
        mac_timer_pkg::TIMER_COMPARE_VALUE: next_cur.compare = BUS.wdata;
        mac_timer_pkg::TIMER_PERIOD_LOW: next_cur.period[7:0] = BUS.wdata;
        mac_timer_pkg::TIMER_PERIOD_HIGH: next_cur.period[15:8] = BUS.wdata;
        default: next_cur.compare = next_cur.compare;
      endcase
    end
    // Hardware sets come last so they win over a clear in the same cycle.
    if (cmp_hit) begin
      next_cur.cmp_flag = 1'b1;
    end
    if (per_hit) begin
      next_cur.per_flag = 1'b1;
    end
    // The overflow compare event comes from logic on this clock, so it needs no synchroniser.
    if (OVF_COMPARE_EVENT) begin
      next_cur.ofc_flag = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      cur <= '0;
      cur.count <= {mac_timer_pkg::COUNT_RESET, mac_timer_pkg::COUNT_RESET};
      cur.period <= mac_timer_pkg::PERIOD_RESET;
      cur.cmp_flag <= mac_timer_pkg::CFG_RESET[mac_timer_pkg::CFG_COMPARE_FLAG];
      cur.per_flag <= mac_timer_pkg::CFG_RESET[mac_timer_pkg::CFG_PERIOD_FLAG];
      cur.ofc_flag <= mac_timer_pkg::CFG_RESET[mac_timer_pkg::CFG_OVF_COMPARE_FLAG];
      cur.cmp_src <= mac_timer_pkg::CFG_RESET[mac_timer_pkg::CFG_COMPARE_SOURCE];
      cur.reserved <= mac_timer_pkg::CFG_RESET[mac_timer_pkg::CFG_RESERVED];
      cur.sync_en <= mac_timer_pkg::CFG_RESET[mac_timer_pkg::CFG_SYNC_ENABLE];
      cur.running <= mac_timer_pkg::CFG_RESET[mac_timer_pkg::CFG_RUN];
      cur.run_req <= mac_timer_pkg::CFG_RESET[mac_timer_pkg::CFG_RUN];
    end else begin
      cur <= next_cur;
    end
  end

  assign BUS.rdata = cur.rdata;
  assign BUS.rvalid = cur.rvalid;
  assign TIMER_RUNNING = cur.running;
  assign PERIOD_EVENT = cur.period_event;
endmodule

//--- rtl/mac_timer_pkg.sv
/*
  Package for the MAC timer configuration and count access block: register
  offsets, field positions, reset values and timing constants.
  Assumes a single 200 MHz clock domain shared by both ends.
*/
package mac_timer_pkg;

  // Special function register offsets of the timer.
  localparam logic [7:0] TIMER_COUNT_LOW_BYTE = 8'ha6;
  localparam logic [7:0] TIMER_COUNT_HIGH_BYTE = 8'ha7;
  localparam logic [7:0] TIMER_CONFIGURATION = 8'hc3;
  localparam logic [7:0] TIMER_COMPARE_VALUE = 8'h94;
  localparam logic [7:0] TIMER_PERIOD_LOW = 8'ha4;
  localparam logic [7:0] TIMER_PERIOD_HIGH = 8'ha5;

  // Configuration field positions.
  localparam int CFG_COMPARE_FLAG = 7;
  localparam int CFG_PERIOD_FLAG = 6;
  localparam int CFG_OVF_COMPARE_FLAG = 5;
  localparam int CFG_UNUSED = 4;
  localparam int CFG_COMPARE_SOURCE = 3;
  localparam int CFG_RESERVED = 2;
  localparam int CFG_SYNC_ENABLE = 1;
  localparam int CFG_RUN = 0;

  // Values after reset.
  localparam logic [7:0] CFG_RESET = 8'h02;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [15:0] PERIOD_RESET = 16'hffff;

  // Sync tick: 32.768 kHz derived from the 200 MHz clock.
  localparam int CLOCK_HZ = 200000000;
  localparam int SYNC_TICK_HZ = 32768;
  localparam int SYNC_TICK_CYCLES = CLOCK_HZ / SYNC_TICK_HZ;

  // Controller register map on AHB-Lite (byte addresses, one word apart).
  localparam logic [7:0] CTRL_SFR_ADDR = 8'h00;
  localparam logic [7:0] CTRL_WRITE_DATA = 8'h04;
  localparam logic [7:0] CTRL_COMMAND = 8'h08;
  localparam logic [7:0] CTRL_READ_DATA = 8'h0c;
  localparam logic [7:0] CTRL_STATUS = 8'h10;
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_READ_BIT = 1;

endpackage

//--- rtl/sfr_bus_if.sv
/*
  Special function register bus between the timer and its controller.
  One access per strobe; read data stands the cycle after a read strobe.
*/
`timescale 1ns/1ps
interface sfr_bus_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic rvalid;

  modport controller (output addr, output wdata, output wr, output rd,
    input rdata, input rvalid);
  modport timer (input addr, input wdata, input wr, input rd,
    output rdata, output rvalid);
endinterface

//--- rtl/sync_tick_gen.sv
/*
  Free-running divider that yields a one-cycle tick at the 32.768 kHz rate.
  Assumes the same clock and synchronous reset as the timer.
*/
`timescale 1ns/1ps
module sync_tick_gen #(
  parameter int CYCLES = mac_timer_pkg::SYNC_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  output logic tick
);
  typedef struct packed {
    logic [15:0] count;
    logic tick;
  } state_t;

  state_t cur;
  state_t next_cur;

  always_comb begin
    next_cur = cur;
    next_cur.tick = 1'b0;
    if (cur.count == 16'(CYCLES - 1)) begin
      next_cur.count = 16'h0000;
      next_cur.tick = 1'b1;
    end else begin
      next_cur.count = cur.count + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign tick = cur.tick;
endmodule

//--- rtl/sfr_controller.sv
/*
  Controller end: an AHB-Lite slave whose registers let software issue
  single SFR reads and writes to the timer and collect read data.
  Assumes one AHB master; the response is always OKAY.
*/
`timescale 1ns/1ps
module sfr_controller (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Timer bus
  sfr_bus_if.controller BUS
);
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic busy;
    logic wr;
    logic rd;
    logic ph_write;
    logic ph_valid;
    logic [7:0] ph_addr;
    logic [31:0] hrdata;
  } state_t;

  state_t cur;
  state_t next_cur;

  always_comb begin
    next_cur = cur;
    next_cur.wr = 1'b0;
    next_cur.rd = 1'b0;
    if (BUS.rvalid) begin
      next_cur.rdata = BUS.rdata;
      next_cur.busy = 1'b0;
    end
    if (cur.ph_valid && cur.ph_write) begin
      case (cur.ph_addr)
        mac_timer_pkg::CTRL_SFR_ADDR: next_cur.addr = HWDATA[7:0];
        mac_timer_pkg::CTRL_WRITE_DATA: next_cur.wdata = HWDATA[7:0];
        mac_timer_pkg::CTRL_COMMAND: begin
          next_cur.wr = HWDATA[mac_timer_pkg::CMD_WRITE_BIT];
          next_cur.rd = HWDATA[mac_timer_pkg::CMD_READ_BIT];
          next_cur.busy = HWDATA[mac_timer_pkg::CMD_READ_BIT];
        end
        default: next_cur.addr = cur.addr;
      endcase
    end
    next_cur.ph_valid = HSEL && HREADY && HTRANS[1];
    next_cur.ph_write = HWRITE;
    next_cur.ph_addr = HADDR[7:0];
    next_cur.hrdata = 32'h00000000;
    if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
      case (HADDR[7:0])
        mac_timer_pkg::CTRL_SFR_ADDR: next_cur.hrdata = {24'h000000, cur.addr};
        mac_timer_pkg::CTRL_WRITE_DATA: next_cur.hrdata = {24'h000000, cur.wdata};
        mac_timer_pkg::CTRL_READ_DATA: next_cur.hrdata = {24'h000000, next_cur.rdata};
        mac_timer_pkg::CTRL_STATUS: next_cur.hrdata = {31'h00000000, next_cur.busy};
        default: next_cur.hrdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign HRDATA = cur.hrdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign BUS.addr = cur.addr;
  assign BUS.wdata = cur.wdata;
  assign BUS.wr = cur.wr;
  assign BUS.rd = cur.rd;
endmodule

//--- sim/mac_timer_asserts.sv
/*
  Checker for the timer register bus and the timer status outputs.
  Assumes the bench instantiates it beside the bus joining both ends.
*/
`timescale 1ns/1ps
module mac_timer_asserts (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // Register bus
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  // Status
  input wire logic TIMER_RUNNING,
  input wire logic PERIOD_EVENT
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);

  sequence cfg_wr(logic [1:0] v);
    wr && addr == mac_timer_pkg::TIMER_CONFIGURATION && wdata[1:0] == v;
  endsequence
  sequence cfg_rd_done;
    rvalid && $past(addr) == mac_timer_pkg::TIMER_CONFIGURATION;
  endsequence

  chk_read_answer: assert property (rd |=> rvalid)
    else $error("read strobe got no answer");
  chk_answer_cause: assert property (rvalid |-> $past(rd))
    else $error("answer without read strobe");
  chk_unused_zero: assert property (cfg_rd_done |-> !rdata[4])
    else $error("unused config bit reads one");
  chk_run_status: assert property (cfg_rd_done |-> rdata[0] == $past(TIMER_RUNNING))
    else $error("run bit differs from timer state");
  chk_period_running: assert property (PERIOD_EVENT |-> $past(TIMER_RUNNING))
    else $error("period event while idle");
  chk_idle_quiet: assert property ((!TIMER_RUNNING) [*2] |-> !PERIOD_EVENT)
    else $error("period event after idle cycles");
  chk_start_now: assert property (cfg_wr(2'b01) |-> ##[1:2] TIMER_RUNNING)
    else $error("unsynced start was late");
  chk_stop_now: assert property (cfg_wr(2'b00) |-> ##[1:2] !TIMER_RUNNING)
    else $error("unsynced stop was late");
endmodule

//--- sim/mac_timer_config_and_count_access_tb.sv
/*
  Self-checking bench: software orders reach the timer over AHB-Lite and the controller.
  Assumes one 200 MHz clock and a synchronous active low reset.
*/
`timescale 1ns/1ps
module mac_timer_config_and_count_access_tb;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic ovf_event = 1'b0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic running;
  logic period_event;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  sfr_bus_if bus ();
  mac_timer u_mac_timer (.SYS_CLK(sys_clk), .RESET_N(reset_n), .BUS(bus.timer),
    .OVF_COMPARE_EVENT(ovf_event), .TIMER_RUNNING(running), .PERIOD_EVENT(period_event));
  sfr_controller u_sfr_controller (.SYS_CLK(sys_clk), .RESET_N(reset_n), .HSEL(1'b1),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .BUS(bus.controller));
  mac_timer_asserts u_mac_timer_asserts (.SYS_CLK(sys_clk), .RESET_N(reset_n),
    .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata),
    .rvalid(bus.rvalid), .TIMER_RUNNING(running), .PERIOD_EVENT(period_event));

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Two synced waits of one slow tick each dominate the run length.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checked %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  // Builds a configuration byte from its fields at the package positions.
  function automatic logic [7:0] cfg_value(input logic [2:0] flags, input logic src,
    input logic sync, input logic run);
    logic [7:0] r;
    r = 8'h00;
    r[mac_timer_pkg::CFG_COMPARE_FLAG] = flags[2];
    r[mac_timer_pkg::CFG_PERIOD_FLAG] = flags[1];
    r[mac_timer_pkg::CFG_OVF_COMPARE_FLAG] = flags[0];
    r[mac_timer_pkg::CFG_COMPARE_SOURCE] = src;
    r[mac_timer_pkg::CFG_SYNC_ENABLE] = sync;
    r[mac_timer_pkg::CFG_RUN] = run;
    return r;
  endfunction

  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge sys_clk);
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    q = hrdata;
    if (hresp !== 1'b0) begin
      mismatches++;
      $display("wrong value at %0t: error response", $time);
    end
  endtask

  task automatic wr_sfr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    ahb(mac_timer_pkg::CTRL_SFR_ADDR, 1'b1, {24'h0, a}, q);
    ahb(mac_timer_pkg::CTRL_WRITE_DATA, 1'b1, {24'h0, d}, q);
    ahb(mac_timer_pkg::CTRL_COMMAND, 1'b1, 32'h1, q);
  endtask

  // The status poll is bounded so a stuck busy bit shows as a wrong value.
  task automatic rd_sfr(input logic [7:0] a, output logic [7:0] v);
    logic [31:0] q;
    ahb(mac_timer_pkg::CTRL_SFR_ADDR, 1'b1, {24'h0, a}, q);
    ahb(mac_timer_pkg::CTRL_COMMAND, 1'b1, 32'h2, q);
    q = 32'h1;
    for (int n = 0; n < 20 && q[0] !== 1'b0; n++) begin
      ahb(mac_timer_pkg::CTRL_STATUS, 1'b0, 32'h0, q);
    end
    ahb(mac_timer_pkg::CTRL_READ_DATA, 1'b0, 32'h0, q);
    v = q[7:0];
  endtask

  task automatic wait_run(input logic v, input int limit);
    for (int n = 0; n < limit && running !== v; n++) begin
      @(posedge sys_clk);
    end
  endtask

  initial begin
    logic [7:0] v;
    logic [7:0] w;
    logic [7:0] p;
    logic [7:0] c;
    void'($urandom(32'h6813));
    p = 8'(16 + $urandom % 32);
    c = 8'($urandom % p);
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd_sfr(mac_timer_pkg::TIMER_CONFIGURATION, v);
    cmp(v, cfg_value(3'b000, 1'b0, 1'b1, 1'b0), "config after reset");
    rd_sfr(mac_timer_pkg::TIMER_COUNT_HIGH_BYTE, v);
    cmp(v, mac_timer_pkg::COUNT_RESET, "high byte after reset");
    $display("test reset done");
    wr_sfr(mac_timer_pkg::TIMER_PERIOD_LOW, p);
    wr_sfr(mac_timer_pkg::TIMER_PERIOD_HIGH, 8'h00);
    wr_sfr(mac_timer_pkg::TIMER_COMPARE_VALUE, c);
    wr_sfr(mac_timer_pkg::TIMER_CONFIGURATION, 8'h09);
    for (int n = 0; n < 100 && period_event !== 1'b1; n++) @(posedge sys_clk);
    rd_sfr(mac_timer_pkg::TIMER_CONFIGURATION, v);
    cmp(v, cfg_value(3'b110, 1'b1, 1'b0, 1'b1), "flags after counting");
    $display("test count done");
    @(posedge sys_clk) ovf_event <= 1'b1;
    @(posedge sys_clk) ovf_event <= 1'b0;
    wr_sfr(mac_timer_pkg::TIMER_CONFIGURATION, 8'he9);
    rd_sfr(mac_timer_pkg::TIMER_CONFIGURATION, v);
    cmp(v & 8'h20, cfg_value(3'b001, 1'b0, 1'b0, 1'b0), "ones leave flags");
    wr_sfr(mac_timer_pkg::TIMER_COMPARE_VALUE, 8'h80);
    wr_sfr(mac_timer_pkg::TIMER_CONFIGURATION, 8'h01);
    rd_sfr(mac_timer_pkg::TIMER_CONFIGURATION, v);
    cmp(v & 8'hbf, cfg_value(3'b000, 1'b0, 1'b0, 1'b1), "zeros clear flags");
    // The event pulse meets the clearing write at the same timer edge.
    wr_sfr(mac_timer_pkg::TIMER_CONFIGURATION, 8'h01);
    ovf_event <= 1'b1;
    @(posedge sys_clk) ovf_event <= 1'b0;
    rd_sfr(mac_timer_pkg::TIMER_CONFIGURATION, v);
    cmp(v & 8'h20, cfg_value(3'b001, 1'b0, 1'b0, 1'b0), "set beats clear");
    $display("test flags done");
    wr_sfr(mac_timer_pkg::TIMER_COUNT_LOW_BYTE, 8'h00);
    wr_sfr(mac_timer_pkg::TIMER_COUNT_HIGH_BYTE, 8'h10);
    rd_sfr(mac_timer_pkg::TIMER_COUNT_LOW_BYTE, v);
    rd_sfr(mac_timer_pkg::TIMER_COUNT_LOW_BYTE, w);
    cmp(w, v, "count halts for delta");
    wr_sfr(mac_timer_pkg::TIMER_CONFIGURATION, 8'h00);
    wait_run(1'b0, 10);
    cmp({7'h0, running}, 8'h00, "immediate stop");
    v = 8'($urandom);
    w = 8'($urandom);
    wr_sfr(mac_timer_pkg::TIMER_COUNT_LOW_BYTE, v);
    wr_sfr(mac_timer_pkg::TIMER_COUNT_HIGH_BYTE, w);
    rd_sfr(mac_timer_pkg::TIMER_COUNT_LOW_BYTE, p);
    cmp(p, v, "idle low load");
    rd_sfr(mac_timer_pkg::TIMER_COUNT_HIGH_BYTE, p);
    cmp(p, w, "idle high load");
    $display("test load done");
    wr_sfr(mac_timer_pkg::TIMER_CONFIGURATION, 8'h03);
    wait_run(1'b1, 7000);
    cmp({7'h0, running}, 8'h01, "synced start");
    wr_sfr(mac_timer_pkg::TIMER_CONFIGURATION, 8'h02);
    rd_sfr(mac_timer_pkg::TIMER_CONFIGURATION, v);
    cmp(v & 8'h01, 8'h01, "run before synced stop");
    wait_run(1'b0, 7000);
    cmp({7'h0, running}, 8'h00, "synced stop");
    $display("test sync done");
    wrap_up();
  end
endmodule
